// >>> hdl/hbd_defines.vh
/*
 Constants for the HDLC buffer-descriptor handler: descriptor field positions,
 register offsets, receive error codes and timing counts. Assumes inclusion by bare name.
*/
`ifndef HBD_DEFINES_VH
`define HBD_DEFINES_VH
// Descriptor fields.
`define HBD_OWN_BIT 31
`define HBD_POLL_INH_BIT 30
`define HBD_MSG_END_BIT 29
`define HBD_BEND_IRQ_BIT 28
`define HBD_REPEAT_BIT 15
`define HBD_LEN_HI 13
`define HBD_ERR_HI 19
`define HBD_ERR_LO 16
`define HBD_MAX_RX_LEN 14'h2000
// Receive error codes.
`define HBD_ERR_OK 4'h0
`define HBD_ERR_OVFL 4'h1
`define HBD_ERR_COFA 4'h2
`define HBD_ERR_OOF 4'h8
`define HBD_ERR_FCS 4'h9
`define HBD_ERR_ALIGN 4'hA
`define HBD_ERR_ABORT 4'hB
`define HBD_ERR_LONG 4'hC
// Register byte offsets.
`define HBD_REG_CTRL 8'h00
`define HBD_REG_STAT 8'h04
`define HBD_REG_MASK 8'h08
`define HBD_REG_TXD 8'h0C
`define HBD_REG_RXD 8'h10
`define HBD_REG_TXS 8'h14
`define HBD_REG_RXS 8'h18
`define HBD_REG_CHAN 8'h1C
// Control bits.
`define HBD_CTRL_TX_ACT 0
`define HBD_CTRL_RX_ACT 1
`define HBD_CTRL_TRANSP 2
`define HBD_CTRL_INH_TBSD 3
`define HBD_CTRL_INH_RBSD 4
// Status bits.
`define HBD_ST_TX_BEND 0
`define HBD_ST_RX_BEND 1
`define HBD_ST_TX_DONE 2
`define HBD_ST_RX_DONE 3
`define HBD_ST_RX_DEACT 4
`define HBD_ST_W 5
// Timing.
`define HBD_POLL_NS 32'd10000
`define HBD_CLK_NS 32'd100
`define HBD_POLL_CYC (`HBD_POLL_NS / `HBD_CLK_NS)
`endif

// >>> hdl/hbd_handler.v
/*
 HDLC buffer-descriptor handler: one transmit and one receive channel fetch
 descriptors from shared memory, honour their fields and write status back.
 Assumes a synchronous descriptor-memory port answering each request with a
 one-cycle ack, a serial engine giving octet handshakes, and an AHB-Lite master.
*/
// Function
// - Transmit bit 15 set repeats the message; the handler repeats only when bit 29 is also set.
// - Transmit bits 13:0 give octets to send.
// - Receive bit 31 one: host owns, idle.
// - Transparent mode: host-owned receive deactivates channel.
// - poll_inhibit clear polls; set waits activation.
// - buffer_end_irq_enable gates buffer_end_event.
// - Receive bits 13:0 give buffer capacity, capped at 0x2000 octets.
// - Status descriptor overwrites the buffer descriptor.
// - Ownership polarity opposite for transmit, receive.
// - Done status: transmit owner 0, receive 1.
// - Transmit status copies message_end_flag bit 29.
// - Transmit status length is octets sent.
// - Receive message_end_flag on closing flag or error.
// - Receive error field zero or termination code.
// - Transmit owner one gives buffer to device.
`timescale 1ns/100ps
`include "hbd_defines.vh"
module hbd_handler #(
	parameter POLL_CYCLES = `HBD_POLL_CYC
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	output reg mem_req,
	output reg mem_we,
	output reg [31:0] mem_addr,
	output reg [31:0] mem_wdata,
	input wire [31:0] mem_rdata,
	input wire mem_ack,
	output reg tx_octet_valid,
	output reg tx_message_end,
	input wire tx_octet_ready,
	input wire rx_octet_valid,
	input wire rx_message_end,
	input wire [3:0] rx_error,
	output reg irq
);
	localparam ST_IDLE = 3'd0;
	localparam ST_FETCH = 3'd1;
	localparam ST_WAIT = 3'd2;
	localparam ST_RUN = 3'd3;
	localparam ST_WBACK = 3'd4;
	localparam ST_OFF = 3'd5;
	reg [4:0] ctrl;
	reg [`HBD_ST_W-1:0] stat;
	reg [`HBD_ST_W-1:0] mask;
	reg [31:0] tx_desc_addr;
	reg [31:0] rx_desc_addr;
	reg [31:0] tx_status;
	reg [31:0] rx_status;
	reg [2:0] tx_state;
	reg [2:0] rx_state;
	reg [31:0] tx_desc;
	reg [31:0] rx_desc;
	reg [13:0] tx_count;
	reg [13:0] rx_count;
	reg [31:0] tx_poll;
	reg [31:0] rx_poll;
	reg tx_bus;
	reg rx_bus;
	reg ph_valid;
	reg ph_write;
	reg [7:0] ph_addr;
	reg [`HBD_ST_W-1:0] ev;
	reg [31:0] next_rdata;
	reg tx_act_pulse;
	reg rx_act_pulse;
	wire [13:0] tx_len = tx_desc[`HBD_LEN_HI:0];
	wire [13:0] rx_cap = (rx_desc[`HBD_LEN_HI:0] > `HBD_MAX_RX_LEN) ? `HBD_MAX_RX_LEN :
		rx_desc[`HBD_LEN_HI:0];
	wire mem_free = !mem_req;
	// Transmit has priority on the memory port.
	// Receive holds off while transmit wants the port, so that one ack can never be taken by both channels.
	wire tx_wants_mem = (tx_state == ST_FETCH) | (tx_state == ST_WBACK);
	// Reads are decoded in the address phase so that the data stands for the whole data phase.
	wire [7:0] rd_addr = {haddr[7:2], 2'b00};
	wire rd_take = hready & hsel & htrans[1] & !hwrite;

	// AHB-Lite slave with zero wait states; every transfer answers OKAY.
	always @* begin
		case (rd_addr)
			`HBD_REG_CTRL: next_rdata = {27'h000_0000, ctrl};
			`HBD_REG_STAT: next_rdata = {27'h000_0000, stat};
			`HBD_REG_MASK: next_rdata = {27'h000_0000, mask};
			`HBD_REG_TXD: next_rdata = tx_desc_addr;
			`HBD_REG_RXD: next_rdata = rx_desc_addr;
			`HBD_REG_TXS: next_rdata = tx_status;
			`HBD_REG_RXS: next_rdata = rx_status;
			`HBD_REG_CHAN: next_rdata = {26'h000_0000, rx_state, tx_state};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
		end else begin
			if (hready) begin
				ph_valid <= hsel & htrans[1];
				ph_write <= hwrite;
				ph_addr <= {haddr[7:2], 2'b00};
			end
			// A read right behind a write to the same register returns the old value.
			// Software that needs the new value must leave one idle cycle between them.
			if (rd_take)
				hrdata <= next_rdata;
		end
	end

	// Register writes land at the end of their data phase.
	// Activate bits act once per write; ctrl keeps them only for read-back.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= 5'h00;
			mask <= {`HBD_ST_W{1'b0}};
			stat <= {`HBD_ST_W{1'b0}};
			tx_desc_addr <= 32'h0000_0000;
			rx_desc_addr <= 32'h0000_0000;
			tx_act_pulse <= 1'b0;
			rx_act_pulse <= 1'b0;
			irq <= 1'b0;
		end else begin
			tx_act_pulse <= 1'b0;
			rx_act_pulse <= 1'b0;
			if (ph_valid & ph_write) begin
				case (ph_addr)
					`HBD_REG_CTRL: begin
						ctrl <= hwdata[4:0];
						tx_act_pulse <= hwdata[`HBD_CTRL_TX_ACT];
						rx_act_pulse <= hwdata[`HBD_CTRL_RX_ACT];
					end
					`HBD_REG_MASK: mask <= hwdata[`HBD_ST_W-1:0];
					`HBD_REG_TXD: tx_desc_addr <= {hwdata[31:2], 2'b00};
					`HBD_REG_RXD: rx_desc_addr <= {hwdata[31:2], 2'b00};
					default: ;
				endcase
			end
			// A new event wins over a write-one clear in the same cycle.
			if (ph_valid & ph_write & (ph_addr == `HBD_REG_STAT))
				stat <= (stat & ~hwdata[`HBD_ST_W-1:0]) | ev;
			else
				stat <= stat | ev;
			irq <= |((stat | ev) & mask);
		end
	end

	// Transmit channel.
	// A descriptor that the host still owns sends the channel to a timed re-read.
	// With polling inhibited it waits for the next activate write instead.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_state <= ST_IDLE;
			tx_desc <= 32'h0000_0000;
			tx_count <= 14'h0000;
			tx_poll <= 32'h0000_0000;
			tx_status <= 32'h0000_0000;
			tx_octet_valid <= 1'b0;
			tx_message_end <= 1'b0;
			tx_bus <= 1'b0;
		end else begin
			case (tx_state)
				ST_IDLE: if (tx_act_pulse) tx_state <= ST_FETCH;
				ST_FETCH: if (tx_bus & mem_ack) begin
					tx_bus <= 1'b0;
					tx_desc <= mem_rdata;
					tx_count <= 14'h0000;
					if (mem_rdata[`HBD_OWN_BIT])
						tx_state <= ST_RUN;
					else begin
						tx_poll <= POLL_CYCLES;
						tx_state <= ST_WAIT;
					end
				end else if (!tx_bus & mem_free & !rx_bus)
					tx_bus <= 1'b1;
				ST_WAIT: if (!tx_desc[`HBD_POLL_INH_BIT]) begin
					if (tx_poll <= 32'd1)
						tx_state <= ST_FETCH;
					else
						tx_poll <= tx_poll - 32'd1;
				end else if (tx_act_pulse)
					tx_state <= ST_FETCH;
				ST_RUN: begin
					tx_octet_valid <= tx_count < tx_len;
					if (tx_octet_valid & tx_octet_ready) begin
						tx_count <= tx_count + 14'h0001;
						tx_octet_valid <= 1'b0;
						tx_message_end <= tx_desc[`HBD_MSG_END_BIT] & (tx_count + 14'h0001 == tx_len);
					end else if (!tx_octet_valid & (tx_count >= tx_len)) begin
						tx_message_end <= 1'b0;
						// Repeat reuses the buffer without any write-back or fetch.
						if (tx_desc[`HBD_REPEAT_BIT] & tx_desc[`HBD_MSG_END_BIT])
							tx_count <= 14'h0000;
						else begin
							tx_status <= {1'b0, 1'b0, tx_desc[`HBD_MSG_END_BIT], 15'h0000, tx_count};
							tx_state <= ctrl[`HBD_CTRL_INH_TBSD] ? ST_IDLE : ST_WBACK;
						end
					end
				end
				ST_WBACK: if (tx_bus & mem_ack) begin
					tx_bus <= 1'b0;
					tx_state <= ST_IDLE;
				end else if (!tx_bus & mem_free & !rx_bus)
					tx_bus <= 1'b1;
				default: tx_state <= ST_IDLE;
			endcase
		end
	end

	// Receive channel.
	// The ownership sense is the inverse of transmit, so a finished receive buffer
	// can be handed to a transmit channel without the host touching it.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_state <= ST_IDLE;
			rx_desc <= 32'h0000_0000;
			rx_count <= 14'h0000;
			rx_poll <= 32'h0000_0000;
			rx_status <= 32'h0000_0000;
			rx_bus <= 1'b0;
		end else begin
			case (rx_state)
				ST_IDLE, ST_OFF: if (rx_act_pulse) rx_state <= ST_FETCH;
				ST_FETCH: if (rx_bus & mem_ack) begin
					rx_bus <= 1'b0;
					rx_desc <= mem_rdata;
					rx_count <= 14'h0000;
					if (!mem_rdata[`HBD_OWN_BIT])
						rx_state <= ST_RUN;
					else if (ctrl[`HBD_CTRL_TRANSP])
						rx_state <= ST_OFF;
					else begin
						rx_poll <= POLL_CYCLES;
						rx_state <= ST_WAIT;
					end
				end else if (!rx_bus & mem_free & !tx_bus & !tx_wants_mem)
					rx_bus <= 1'b1;
				ST_WAIT: if (!rx_desc[`HBD_POLL_INH_BIT]) begin
					if (rx_poll <= 32'd1)
						rx_state <= ST_FETCH;
					else
						rx_poll <= rx_poll - 32'd1;
				end else if (rx_act_pulse)
					rx_state <= ST_FETCH;
				ST_RUN: if (rx_octet_valid) begin
					// The engine flags the message end, with its error code, on the last octet.
					rx_count <= rx_count + 14'h0001;
					if (rx_message_end | (rx_count + 14'h0001 >= rx_cap)) begin
						rx_status <= {1'b1, 1'b0, rx_message_end, 9'h000,
							(rx_message_end ? rx_error : `HBD_ERR_OK), 2'b00, rx_count + 14'h0001};
						rx_state <= ctrl[`HBD_CTRL_INH_RBSD] ? ST_IDLE : ST_WBACK;
					end
				end
				ST_WBACK: if (rx_bus & mem_ack) begin
					rx_bus <= 1'b0;
					rx_state <= ST_IDLE;
				end else if (!rx_bus & mem_free & !tx_bus & !tx_wants_mem)
					rx_bus <= 1'b1;
				default: rx_state <= ST_IDLE;
			endcase
		end
	end

	// Memory port: one outstanding request, transmit served ahead of receive.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 32'h0000_0000;
			mem_wdata <= 32'h0000_0000;
		end else if (mem_req) begin
			if (mem_ack)
				mem_req <= 1'b0;
		end else if (tx_bus & !mem_ack & ((tx_state == ST_FETCH) | (tx_state == ST_WBACK))) begin
			mem_req <= 1'b1;
			mem_we <= tx_state == ST_WBACK;
			mem_addr <= tx_desc_addr;
			mem_wdata <= tx_status;
		end else if (rx_bus & !mem_ack & ((rx_state == ST_FETCH) | (rx_state == ST_WBACK))) begin
			mem_req <= 1'b1;
			mem_we <= rx_state == ST_WBACK;
			mem_addr <= rx_desc_addr;
			mem_wdata <= rx_status;
		end
	end

	// Events are one-cycle strobes; the status register makes them sticky.
	always @* begin
		ev = {`HBD_ST_W{1'b0}};
		ev[`HBD_ST_TX_BEND] = (tx_state == ST_RUN) & !tx_octet_valid & (tx_count >= tx_len) &
			tx_desc[`HBD_BEND_IRQ_BIT] & !(tx_desc[`HBD_REPEAT_BIT] & tx_desc[`HBD_MSG_END_BIT]);
		ev[`HBD_ST_RX_BEND] = (rx_state == ST_RUN) & rx_octet_valid & rx_desc[`HBD_BEND_IRQ_BIT] &
			(rx_count + 14'h0001 >= rx_cap);
		ev[`HBD_ST_TX_DONE] = (tx_state == ST_WBACK) & tx_bus & mem_ack;
		ev[`HBD_ST_RX_DONE] = (rx_state == ST_WBACK) & rx_bus & mem_ack;
		ev[`HBD_ST_RX_DEACT] = (rx_state == ST_FETCH) & rx_bus & mem_ack & mem_rdata[`HBD_OWN_BIT] &
			ctrl[`HBD_CTRL_TRANSP];
	end
endmodule // hbd_handler

// >>> verification/hbd_host_mem.sv
/* Host-side descriptor memory model for the handler's memory port.
 Assumes one outstanding request, held until acknowledged. */
`timescale 1ns/100ps
module hbd_host_mem (
	input wire hclk,
	input wire slow,
	input wire mem_req,
	input wire mem_we,
	input wire [31:0] mem_addr,
	input wire [31:0] mem_wdata,
	output logic [31:0] mem_rdata,
	output logic mem_ack
);
	logic [31:0] m [0:15];
	int waited = 0;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 32'h0000_0000;
	end
	always @(posedge hclk) begin
		mem_ack <= 1'b0;
		// Read data is only valid with an ack, so it keeps moving otherwise.
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack) begin
			if (waited < (slow ? 3 : 0)) begin
				waited <= waited + 1;
			end else begin
				waited <= 0;
				mem_ack <= 1'b1;
				if (mem_we) begin
					m[mem_addr[5:2]] <= mem_wdata;
				end else begin
					mem_rdata <= m[mem_addr[5:2]];
				end
			end
		end
	end
endmodule // hbd_host_mem

// >>> verification/hbd_handler_props.sv
/* Port assertions for the descriptor handler.
 Assumes it is bound into hbd_handler and sees only its ports. */
`timescale 1ns/100ps
module hbd_props #(
	parameter POLL_CYCLES = 3
) (
	input wire hclk,
	input wire hresetn,
	input wire mem_req,
	input wire mem_we,
	input wire [31:0] mem_addr,
	input wire [31:0] mem_wdata,
	input wire mem_ack,
	input wire tx_octet_valid,
	input wire tx_octet_ready,
	input wire tx_message_end,
	input wire irq
);
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	wire wb = mem_req && mem_we;
	wire rxs = wb && mem_wdata[31];
	logic [13:0] sent;
	// Octets taken since the last transmit status, to match its length field.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sent <= 14'h0000;
		end else if (wb && mem_ack && !mem_wdata[31]) begin
			sent <= 14'h0000;
		end else if (tx_octet_valid && tx_octet_ready) begin
			sent <= sent + 14'h0001;
		end
	end
	a_wb_reserved: assert property (wb |-> !mem_wdata[30] && (mem_wdata[31] ?
		(mem_wdata[28:20] == 9'h000 && mem_wdata[15:14] == 2'h0) : mem_wdata[28:14] == 15'h0000))
		else $error("reserved status bits set");
	a_err_code: assert property (rxs |-> mem_wdata[19:16] inside {[0:2], [8:12]})
		else $error("bad receive error code");
	a_err_ends: assert property (rxs && mem_wdata[19:16] != 4'h0 |-> mem_wdata[29])
		else $error("error without message end");
	a_tx_len: assert property (wb && !mem_wdata[31] |-> mem_wdata[13:0] == sent)
		else $error("transmit length differs from octets sent");
	a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
		&& $stable(mem_we) && $stable(mem_wdata)) else $error("memory request changed");
	a_req_drop: assert property (mem_req && mem_ack |=> !mem_req)
		else $error("memory request held after ack");
	a_end_take: assert property (tx_message_end |-> $past(tx_octet_valid && tx_octet_ready))
		else $error("message end without octet taken");
	a_valid_hold: assert property (tx_octet_valid && !tx_octet_ready |=> tx_octet_valid)
		else $error("octet offer withdrawn");
	cover property (rxs && mem_ack);
	cover property (wb && mem_ack && !mem_wdata[31]);
	cover property ($rose(irq));
endmodule // hbd_props
bind hbd_handler hbd_props #(.POLL_CYCLES(POLL_CYCLES)) u_props (.hclk, .hresetn, .mem_req, .mem_we,
	.mem_addr, .mem_wdata, .mem_ack, .tx_octet_valid, .tx_octet_ready, .tx_message_end, .irq);

// >>> verification/tb.sv
/* Self-checking bench for hbd_handler against a host memory model.
 Assumes the memory model and the bound checker are compiled first. */
`timescale 1ns/100ps
`include "hbd_defines.vh"
module tb;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd;
	logic [1:0] htrans = 2'b00;
	logic [3:0] rx_error = 4'h0;
	logic rx_octet_valid = 1'b0, rx_message_end = 1'b0, tx_octet_ready = 1'b0;
	wire hreadyout, hresp, mem_req, mem_we, mem_ack, tx_octet_valid, tx_message_end, irq;
	wire [31:0] hrdata, mem_addr, mem_wdata, mem_rdata;
	int mismatches = 0, samples_checked = 0, cycles = 0, tx_cnt = 0, end_cnt = 0, n0, e0;
	hbd_handler #(.POLL_CYCLES(3)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.mem_rdata, .mem_ack, .tx_octet_valid, .tx_message_end, .tx_octet_ready, .rx_octet_valid,
		.rx_message_end, .rx_error, .irq);
	hbd_host_mem host (.hclk, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
	initial forever #50 hclk = ~hclk;
	always @(posedge hclk) begin
		// The engine stalls every other cycle so offers must be held.
		tx_octet_ready <= ~tx_octet_ready;
		tx_cnt <= tx_cnt + (tx_octet_valid && tx_octet_ready);
		end_cnt <= end_cnt + tx_message_end;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up();
		end
	end
	task wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task check(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task poll(input logic [7:0] a, input logic [31:0] m, v);
		do bus(1'b0, a, 32'h0000_0000); while ((rd & m) !== v);
	endtask
	task rx_oct(input logic e, input logic [3:0] err);
		rx_octet_valid <= 1'b1;
		rx_message_end <= e;
		rx_error <= err;
		@(posedge hclk);
		rx_octet_valid <= 1'b0;
		rx_message_end <= 1'b0;
		@(posedge hclk);
	endtask
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b1, 8'h40, 32'hFFFF_FFFF);
		bus(1'b0, 8'h40, 32'h0000_0000);
		check("unmapped", rd, 32'h0000_0000);
		check("okay", hresp, 32'h0000_0000);
		host.m[1] = 32'hB000_0003;
		bus(1'b1, `HBD_REG_TXD, 32'h0000_0004);
		bus(1'b1, `HBD_REG_MASK, 32'h0000_001F);
		n0 = tx_cnt;
		e0 = end_cnt;
		bus(1'b1, `HBD_REG_CTRL, 32'h0000_0001);
		poll(`HBD_REG_STAT, 32'h0000_0004, 32'h0000_0004);
		check("tx stat", rd, 32'h0000_0005);
		check("tx octets", tx_cnt - n0, 32'h0000_0003);
		check("tx ends", end_cnt - e0, 32'h0000_0001);
		check("tx status", host.m[1], 32'h2000_0003);
		check("irq set", irq, 32'h0000_0001);
		bus(1'b1, `HBD_REG_MASK, 32'h0000_0000);
		bus(1'b0, `HBD_REG_TXS, 32'h0000_0000);
		check("tx status reg", rd, 32'h2000_0003);
		check("irq masked", irq, 32'h0000_0000);
		bus(1'b1, `HBD_REG_STAT, 32'h0000_001F);
		bus(1'b1, `HBD_REG_MASK, 32'h0000_001F);
		check("irq cleared", irq, 32'h0000_0000);
		slow <= 1'b1;
		host.m[2] = 32'h1000_0002;
		bus(1'b1, `HBD_REG_RXD, 32'h0000_0008);
		bus(1'b1, `HBD_REG_CTRL, 32'h0000_0002);
		poll(`HBD_REG_CHAN, 32'h0000_0038, 32'h0000_0018);
		rx_oct(1'b0, 4'h0);
		rx_oct(1'b1, 4'h9);
		poll(`HBD_REG_STAT, 32'h0000_0008, 32'h0000_0008);
		check("rx stat", rd, 32'h0000_000A);
		check("rx status", host.m[2], 32'hA009_0002);
		bus(1'b1, `HBD_REG_STAT, 32'h0000_001F);
		host.m[3] = 32'h8000_0001;
		bus(1'b1, `HBD_REG_RXD, 32'h0000_000C);
		bus(1'b1, `HBD_REG_CTRL, 32'h0000_0002);
		repeat (20) @(posedge hclk);
		bus(1'b0, `HBD_REG_CHAN, 32'h0000_0000);
		check("rx idles", 32'((rd & 32'h0000_0038) inside {32'h0000_0008, 32'h0000_0010}), 32'h0000_0001);
		check("rx no write", host.m[3], 32'h8000_0001);
		host.m[3] = 32'h0000_0001;
		// Only periodic re-reading of the descriptor can end this wait.
		poll(`HBD_REG_CHAN, 32'h0000_0038, 32'h0000_0018);
		rx_oct(1'b1, 4'h0);
		poll(`HBD_REG_STAT, 32'h0000_0008, 32'h0000_0008);
		check("rx ok", host.m[3], 32'hA000_0001);
		bus(1'b1, `HBD_REG_STAT, 32'h0000_001F);
		host.m[3] = 32'hC000_0001;
		bus(1'b1, `HBD_REG_CTRL, 32'h0000_0002);
		poll(`HBD_REG_CHAN, 32'h0000_0038, 32'h0000_0010);
		host.m[3] = 32'h0000_0001;
		repeat (20) @(posedge hclk);
		bus(1'b0, `HBD_REG_CHAN, 32'h0000_0000);
		check("rx inhibit waits", rd & 32'h0000_0038, 32'h0000_0010);
		bus(1'b1, `HBD_REG_CTRL, 32'h0000_0002);
		poll(`HBD_REG_CHAN, 32'h0000_0038, 32'h0000_0018);
		rx_oct(1'b1, 4'h0);
		poll(`HBD_REG_STAT, 32'h0000_0008, 32'h0000_0008);
		check("rx after activate", host.m[3], 32'hA000_0001);
		host.m[3] = 32'h8000_0005;
		bus(1'b1, `HBD_REG_STAT, 32'h0000_001F);
		bus(1'b1, `HBD_REG_CTRL, 32'h0000_0006);
		poll(`HBD_REG_STAT, 32'h0000_0010, 32'h0000_0010);
		bus(1'b0, `HBD_REG_CHAN, 32'h0000_0000);
		check("rx off", rd & 32'h0000_0038, 32'h0000_0028);
		host.m[1] = 32'hA000_8002;
		n0 = tx_cnt;
		bus(1'b1, `HBD_REG_CTRL, 32'h0000_0001);
		repeat (80) @(posedge hclk);
		check("tx repeats", 32'(tx_cnt - n0 > 4), 32'h0000_0001);
		check("no status", host.m[1], 32'hA000_8002);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, `HBD_REG_STAT, 32'h0000_0000);
		check("stat reset", rd, 32'h0000_0000);
		wrap_up();
	end
endmodule // tb
